/* File: pmbus_status_pkg.sv */
// Shared constants for the fault status bank and its bus-side controller
package pmbus_status_pkg;
    // Command codes seen on the link
    localparam logic [7:0] CODE_CLEAR_ALL   = 8'h03;
    localparam logic [7:0] CODE_ALERT_MASK  = 8'h1B;
    localparam logic [7:0] CODE_SUM_BYTE    = 8'h78;
    localparam logic [7:0] CODE_SUM_WORD    = 8'h79;
    localparam logic [7:0] CODE_VOUT        = 8'h7A;
    localparam logic [7:0] CODE_IOUT        = 8'h7B;
    localparam logic [7:0] CODE_INPUT       = 8'h7C;
    localparam logic [7:0] CODE_TEMP        = 8'h7D;
    localparam logic [7:0] CODE_CML         = 8'h7E;
    localparam logic [7:0] CODE_VENDOR      = 8'h80;
    // Summary byte bit positions
    localparam int SUM_BUSY_BIT   = 7;
    localparam int SUM_OFF_BIT    = 6;
    localparam int SUM_UNL_BIT    = 0;
    // Status word high-byte bit positions
    localparam int WORD_NPG_BIT   = 11;
    // Per-byte supported, clearable and alerting bit masks
    localparam logic [7:0] SUM_ALERT_BITS  = 8'h81;
    localparam logic [7:0] VOUT_SUP_BITS   = 8'hFE;
    localparam logic [7:0] IOUT_SUP_BITS   = 8'hA0;
    localparam logic [7:0] INPUT_SUP_BITS  = 8'hA8;
    localparam logic [7:0] INPUT_W1C_BITS  = 8'h80;
    localparam logic [7:0] TEMP_SUP_BITS   = 8'hD0;
    localparam logic [7:0] CML_SUP_BITS    = 8'hFB;
    localparam logic [7:0] VENDOR_SUP_BITS = 8'hFB;
    localparam int CML_BAD_CODE_BIT = 7;
    // Alert mask group bits
    localparam int MASK_SUM    = 0;
    localparam int MASK_VOUT   = 1;
    localparam int MASK_IOUT   = 2;
    localparam int MASK_INPUT  = 3;
    localparam int MASK_TEMP   = 4;
    localparam int MASK_CML    = 5;
    localparam int MASK_VENDOR = 6;
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'h00;
    // Controller APB register offsets and fields
    localparam logic [11:0] OFS_COMMAND = 12'h000;
    localparam logic [11:0] OFS_RESULT  = 12'h004;
    localparam int CMD_WRITE_BIT = 8;
    localparam int RES_BUSY_BIT  = 0;
    localparam int RES_ALERT_BIT = 1;
endpackage

/* File: pmbus_link_if.sv */
// Request/answer link between the status bank and its controller
`timescale 1ns/10ps
interface pmbus_link_if;
    logic        req;      // Request held until ack
    logic        wr;       // 1 write, 0 read
    logic [7:0]  code;     // Command code
    logic [15:0] wdata;    // Write data
    logic        ack;      // One-cycle answer
    logic [15:0] rdata;    // Read data, valid with ack
    logic        alert_n;  // Alert line, low active
    modport dev_mp (input req, wr, code, wdata, output ack, rdata, alert_n);
    modport host_mp (output req, wr, code, wdata, input ack, rdata, alert_n);
endinterface

/* File: pmbus_fault_status_bank.sv */
// Per-channel fault and warning status bank with alert output
//
// Overview of operation
// - Summary bit 7 flags failure to respond.
// - Summary bit 6 set while output off.
// - Bit5 output OV, bit4 OC, bit3 zero.
// - Bit2 temperature, bit1 comm/memory/logic fault.
// - Bit0 flags faults not listed elsewhere.
// - Only summary bits 7,0 alert; write-1 clears.
// - Word low byte equals summary byte.
// - Word bits 15-12 group flags; 10-8 zero.
// - Word bit 11 set when power not good.
// - Voltage byte bits 7-1 flags; bit0 zero.
// - Voltage byte bits clear by writing one.
// - Current byte bits 7,5 only; rest zero.
// - Current, temp, comm bits alert, write-1 clear.
// - Input byte bits 7,5,3 only; rest zero.
// - Input byte: only bit7 alerts and clears.
// - Temp byte: over fault, warning, under fault.
// - Comm byte bit7 bad code, bit6 bad data.
// - Comm bit5 PEC error, bit1 other; bit2 zero.
// - Comm bit4 memory, bit3 processor, bit0 other.
// - Clear-all empties every status register, not the mask; releases alert.
// - Persisting faults stay set through a clear.
// - Vendor bits set word bit 12, may alert.
// - Events alert only when not masked.
`timescale 1ns/10ps
module pmbus_fault_status_bank (
    input  wire logic        clk_sys_in,         // System clock
    input  wire logic        reset_in,           // Synchronous reset
    pmbus_link_if.dev_mp     link,               // Host link
    input  wire logic        busy_fault_in,      // Could not answer in time
    input  wire logic        channel_off_in,     // Output not powered
    input  wire logic        power_good_in,      // Power good condition
    input  wire logic        unlisted_fault_in,  // Fault of no other class
    input  wire logic [7:0]  vout_cond_in,       // Output voltage conditions
    input  wire logic [7:0]  iout_cond_in,       // Output current conditions
    input  wire logic [7:0]  input_cond_in,      // Input supply conditions
    input  wire logic [7:0]  temp_cond_in,       // External temperature conditions
    input  wire logic [7:0]  cml_cond_in,        // Comm, memory, logic conditions
    input  wire logic [7:0]  vendor_cond_in      // Vendor-specific conditions
);
    import pmbus_status_pkg::*;

    localparam int SYNC_W = 52;

    // Sticky bit update: set wins over any clear, unsupported bits stay zero
    function automatic logic [7:0] sticky(input logic [7:0] q, input logic [7:0] set,
                                          input logic [7:0] w1c, input logic clr,
                                          input logic [7:0] sup);
        sticky = ((q & ~w1c & ~{8{clr}}) | set) & sup;
    endfunction

    logic [SYNC_W-1:0] sync1_q;      // First synchroniser stage
    logic [SYNC_W-1:0] sync2_q;      // Second stage, the only reader of the first
    logic              busy_s;       // Synchronised condition levels
    logic              off_s;
    logic              pg_s;
    logic              unl_s;
    logic [7:0]        vout_s;
    logic [7:0]        iout_s;
    logic [7:0]        input_s;
    logic [7:0]        temp_s;
    logic [7:0]        cml_s;
    logic [7:0]        vendor_s;
    logic [7:0]        sum_q;        // Sticky summary bits 7 and 0
    logic [7:0]        vout_q;       // Detail status bytes
    logic [7:0]        iout_q;
    logic [7:0]        input_q;
    logic [7:0]        temp_q;
    logic [7:0]        cml_q;
    logic [7:0]        vendor_q;
    logic [7:0]        mask_q;       // Alert mask, one bit per group
    logic              ack_q;        // Answer strobe
    logic [15:0]       rdata_q;      // Answer data
    logic              alert_n_q;    // Registered alert line
    logic              take;         // Request accepted this cycle
    logic              wr_take;      // Accepted write
    logic              clr_all;      // Clear-all command
    logic              known;        // Code is mapped
    logic [7:0]        w1c_sum;      // Write-one-to-clear vectors
    logic [7:0]        w1c_vout;
    logic [7:0]        w1c_iout;
    logic [7:0]        w1c_input;
    logic [7:0]        w1c_temp;
    logic [7:0]        w1c_cml;
    logic [7:0]        w1c_vendor;
    logic [7:0]        cml_set;      // Comm byte set terms incl. bad codes
    logic [7:0]        sum_byte;     // Assembled summary byte
    logic [15:0]       word_val;     // Assembled status word
    logic              alert_any;    // Any unmasked alerting bit

    // Two-flop synchroniser for all fault condition pins
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {busy_fault_in, channel_off_in, power_good_in, unlisted_fault_in,
                        vout_cond_in, iout_cond_in, input_cond_in, temp_cond_in,
                        cml_cond_in, vendor_cond_in};
            sync2_q <= sync1_q;
        end
    end

    assign {busy_s, off_s, pg_s, unl_s, vout_s, iout_s, input_s, temp_s, cml_s, vendor_s}
        = sync2_q;

    // A request is taken once; the held req is ignored while ack stands
    assign take    = link.req && !ack_q;
    assign wr_take = take && link.wr;
    assign clr_all = wr_take && (link.code == CODE_CLEAR_ALL);

    // Write decode into per-register clear vectors
    always_comb begin
        w1c_sum    = 8'h00;
        w1c_vout   = 8'h00;
        w1c_iout   = 8'h00;
        w1c_input  = 8'h00;
        w1c_temp   = 8'h00;
        w1c_cml    = 8'h00;
        w1c_vendor = 8'h00;
        known      = 1'b1;
        case (link.code)
            CODE_SUM_BYTE,
            CODE_SUM_WORD: begin
                w1c_sum = link.wdata[7:0] & SUM_ALERT_BITS;
            end
            CODE_VOUT: begin
                w1c_vout = link.wdata[7:0] & VOUT_SUP_BITS;
            end
            CODE_IOUT: begin
                w1c_iout = link.wdata[7:0];
            end
            CODE_INPUT: begin
                w1c_input = link.wdata[7:0] & INPUT_W1C_BITS;
            end
            CODE_TEMP: begin
                w1c_temp = link.wdata[7:0];
            end
            CODE_CML: begin
                w1c_cml = link.wdata[7:0];
            end
            CODE_VENDOR: begin
                w1c_vendor = link.wdata[7:0];
            end
            CODE_ALERT_MASK: begin
                known = 1'b1;
            end
            CODE_CLEAR_ALL: begin
                // Write-only; a read of it is an invalid command
                known = link.wr;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        if (!wr_take) begin
            w1c_sum    = 8'h00;
            w1c_vout   = 8'h00;
            w1c_iout   = 8'h00;
            w1c_input  = 8'h00;
            w1c_temp   = 8'h00;
            w1c_cml    = 8'h00;
            w1c_vendor = 8'h00;
        end
    end

    // Unmapped codes count as invalid commands in the comm byte
    always_comb begin
        cml_set = cml_s;
        if (take && !known) begin
            cml_set[CML_BAD_CODE_BIT] = 1'b1;
        end
    end

    // Summary sticky bits: busy and unlisted fault
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sum_q <= STATUS_RESET;
        end else begin
            sum_q <= sticky(sum_q, {busy_s, 6'h00, unl_s}, w1c_sum, clr_all,
                            SUM_ALERT_BITS);
        end
    end

    // Detail status bytes; a persisting condition keeps its bit set through a clear
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            vout_q   <= STATUS_RESET;
            iout_q   <= STATUS_RESET;
            input_q  <= STATUS_RESET;
            temp_q   <= STATUS_RESET;
            cml_q    <= STATUS_RESET;
            vendor_q <= STATUS_RESET;
        end else begin
            vout_q   <= sticky(vout_q, vout_s, w1c_vout, clr_all, VOUT_SUP_BITS);
            iout_q   <= sticky(iout_q, iout_s, w1c_iout, clr_all, IOUT_SUP_BITS);
            input_q  <= sticky(input_q, input_s, w1c_input, clr_all,
                               INPUT_SUP_BITS);
            temp_q   <= sticky(temp_q, temp_s, w1c_temp, clr_all,
                               TEMP_SUP_BITS);
            cml_q    <= sticky(cml_q, cml_set, w1c_cml, clr_all, CML_SUP_BITS);
            vendor_q <= sticky(vendor_q, vendor_s, w1c_vendor, clr_all, VENDOR_SUP_BITS);
        end
    end

    // Alert mask register, written by its own command code
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            mask_q <= MASK_RESET;
        end else if (wr_take && link.code == CODE_ALERT_MASK) begin
            mask_q <= link.wdata[7:0];
        end
    end

    // Summary byte: off is live, class bits follow the detail bytes
    assign sum_byte = {sum_q[SUM_BUSY_BIT],
                       off_s,
                       vout_q[7], iout_q[7], 1'b0,
                       |temp_q, |cml_q,
                       sum_q[SUM_UNL_BIT]};

    // Word: group flags, live not-power-good, unsupported zeros, summary low
    assign word_val = {|vout_q, |iout_q, |input_q, |vendor_q,
                       ~pg_s,
                       3'b000,
                       sum_byte};

    // Read mux and one-cycle answer strobe
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ack_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q <= take;
            if (take && !link.wr) begin
                case (link.code)
                    CODE_SUM_BYTE:   rdata_q <= {8'h00, sum_byte};
                    CODE_SUM_WORD:   rdata_q <= word_val;
                    CODE_VOUT:       rdata_q <= {8'h00, vout_q};
                    CODE_IOUT:       rdata_q <= {8'h00, iout_q};
                    CODE_INPUT:      rdata_q <= {8'h00, input_q};
                    CODE_TEMP:       rdata_q <= {8'h00, temp_q};
                    CODE_CML:        rdata_q <= {8'h00, cml_q};
                    CODE_VENDOR:     rdata_q <= {8'h00, vendor_q};
                    CODE_ALERT_MASK: rdata_q <= {8'h00, mask_q};
                    default:         rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // Alert sources: only the alerting bits of each byte, gated by the mask
    assign alert_any =
        (|(sum_q & SUM_ALERT_BITS) && !mask_q[MASK_SUM]) ||
        (|(vout_q & VOUT_SUP_BITS) && !mask_q[MASK_VOUT]) ||
        (|iout_q && !mask_q[MASK_IOUT]) ||
        (|(input_q & INPUT_W1C_BITS) && !mask_q[MASK_INPUT]) ||
        (|temp_q && !mask_q[MASK_TEMP]) ||
        (|cml_q && !mask_q[MASK_CML]) ||
        (|vendor_q && !mask_q[MASK_VENDOR]);

    // Registered alert line; released by clear-all unless a fault persists
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            alert_n_q <= 1'b1;
        end else begin
            alert_n_q <= !alert_any;
        end
    end

    assign link.ack     = ack_q;
    assign link.rdata   = rdata_q;
    assign link.alert_n = alert_n_q;
endmodule

/* File: pmbus_status_host.sv */
// Controller end: APB registers that run link transfers to the status bank
`timescale 1ns/10ps
module pmbus_status_host (
    input  wire logic        clk_sys_in,    // System clock
    input  wire logic        reset_in,      // Synchronous reset
    pmbus_link_if.host_mp    link,          // Link to the status bank
    input  wire logic        psel_in,       // APB select
    input  wire logic        penable_in,    // APB enable
    input  wire logic        pwrite_in,     // APB direction
    input  wire logic [11:0] paddr_in,      // APB byte address
    input  wire logic [31:0] pwdata_in,     // APB write data
    output logic      [31:0] prdata_out,    // APB read data
    output logic             pready_out,    // APB ready
    output logic             pslverr_out,   // APB error for unmapped offsets
    output logic             alert_out      // Alert seen on the link, high active
);
    import pmbus_status_pkg::*;

    logic        req_q;     // Link request, held until ack
    logic        wr_q;      // Direction of the pending transfer
    logic [7:0]  code_q;    // Code of the pending transfer
    logic [15:0] wdata_q;   // Data of the pending transfer
    logic [15:0] res_q;     // Last read answer
    logic [31:0] prdata_q;  // Read data captured in the setup cycle
    logic        err_q;     // Error captured in the setup cycle
    logic        setup;     // APB setup cycle
    logic        access;    // APB access completing
    logic        mapped;    // Offset decodes

    assign setup  = psel_in && !penable_in;
    assign access = psel_in && penable_in;
    assign mapped = (paddr_in == OFS_COMMAND) || (paddr_in == OFS_RESULT);

    // Read data and error are latched in setup so outputs come from flops
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
        end else if (setup) begin
            err_q <= !mapped;
            if (paddr_in == OFS_COMMAND) begin
                prdata_q <= {wdata_q, 7'h00, wr_q, code_q};
            end else if (paddr_in == OFS_RESULT) begin
                prdata_q <= {res_q, 14'h0000, !link.alert_n, req_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // A command write starts one link transfer; ignored while one is pending
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            req_q   <= 1'b0;
            wr_q    <= 1'b0;
            code_q  <= 8'h00;
            wdata_q <= 16'h0000;
        end else if (access && pwrite_in && paddr_in == OFS_COMMAND && !req_q) begin
            req_q   <= 1'b1;
            wr_q    <= pwdata_in[CMD_WRITE_BIT];
            code_q  <= pwdata_in[7:0];
            wdata_q <= pwdata_in[31:16];
        end else if (link.ack) begin
            req_q <= 1'b0;
        end
    end

    // Answer data is captured on the answer strobe of a read
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            res_q <= 16'h0000;
        end else if (link.ack && !wr_q) begin
            res_q <= link.rdata;
        end
    end

    assign link.req    = req_q;
    assign link.wr     = wr_q;
    assign link.code   = code_q;
    assign link.wdata  = wdata_q;
    assign prdata_out  = prdata_q;
    assign pready_out  = 1'b1;
    assign pslverr_out = access && err_q;
    assign alert_out   = !link.alert_n;
endmodule

/* File: pmbus_fault_status_bank_props.sv */
// Concurrent checks on the link between the status bank and its controller
`timescale 1ns/10ps
module pmbus_fault_status_bank_props
    import pmbus_status_pkg::*;
(
    input  wire logic        clk_sys_in,  // System clock
    input  wire logic        reset_in,    // Synchronous reset
    input  wire logic        req,         // Link request
    input  wire logic        wr,          // Link direction
    input  wire logic [7:0]  code,        // Command code
    input  wire logic        ack,         // Link answer pulse
    input  wire logic [15:0] rdata        // Read answer
);
    default clocking link_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    // Read answer for one code; the code is still held in the ack cycle
    sequence rd_ans(logic [7:0] c);
        ack && !wr && code == c;
    endsequence
    // One answer pulse, then quiet
    sequence one_answer;
        ack ##1 !ack;
    endsequence

    a_answer_next: assert property ($rose(req) |=> one_answer)
        else $error("request not answered by a single pulse one cycle later");
    a_req_drops: assert property (ack |=> !req)
        else $error("controller kept its request after the answer");
    a_word_high_zero: assert property (rd_ans(CODE_SUM_WORD) |-> rdata[10:8] == 3'h0)
        else $error("word bits 10 to 8 not zero");
    a_sum_bit3_zero: assert property (rd_ans(CODE_SUM_BYTE) |->
        !rdata[3] && rdata[15:8] == 8'h00)
        else $error("summary bit 3 or upper byte not zero");
    a_vout_bit0_zero: assert property (rd_ans(CODE_VOUT) |->
        (rdata & ~{8'h00, VOUT_SUP_BITS}) == 16'h0000)
        else $error("voltage byte unsupported bit set");
    a_iout_mask_ok: assert property (rd_ans(CODE_IOUT) |->
        (rdata & ~{8'h00, IOUT_SUP_BITS}) == 16'h0000)
        else $error("current byte unsupported bit set");
    a_input_mask_ok: assert property (rd_ans(CODE_INPUT) |->
        (rdata & ~{8'h00, INPUT_SUP_BITS}) == 16'h0000)
        else $error("input byte unsupported bit set");
    a_temp_mask_ok: assert property (rd_ans(CODE_TEMP) |->
        (rdata & ~{8'h00, TEMP_SUP_BITS}) == 16'h0000)
        else $error("temperature byte unsupported bit set");
    a_cml_reserved_zero: assert property (rd_ans(CODE_CML) |->
        !rdata[2] && rdata[15:8] == 8'h00)
        else $error("comm byte reserved bit set");
endmodule

/* File: pmbus_fault_status_bank_tb_top.sv */
// Self-checking bench joining the status bank to its APB controller
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module pmbus_fault_status_bank_tb_top;
    import pmbus_status_pkg::*;
    logic        clk_sys_in;  // 40 MHz clock
    logic        reset_in;    // Synchronous reset
    logic        psel;        // APB select
    logic        penable;     // APB enable
    logic        pwrite;      // APB direction
    logic [11:0] paddr;       // APB address
    logic [31:0] pwdata;      // APB write data
    logic [31:0] prdata;      // APB read data
    logic        pready;      // APB ready
    logic        pslverr;     // APB error
    logic        alert;       // Alert seen by the controller
    logic [7:0]  cond [0:5];  // Conditions: vout, iout, input, temp, cml, vendor
    logic [3:0]  lvl;         // Levels: busy, off, power good, unlisted
    int          errors;      // Mismatch count
    int          tests_run;   // Comparison count
    // Read order of the status bytes, with full-fault and after-clear images
    // Off and not-power-good are live, so the full image, read at idle, shows neither
    localparam logic [7:0] codes [0:7] = '{CODE_SUM_BYTE, CODE_SUM_WORD, CODE_VOUT,
        CODE_IOUT, CODE_INPUT, CODE_TEMP, CODE_CML, CODE_VENDOR};
    localparam logic [15:0] full [0:7] = '{16'h00B7, 16'hF0B7, 16'h00FE, 16'h00A0,
        16'h00A8, 16'h00D0, 16'h00FB, 16'h00FB};
    localparam logic [15:0] left [0:7] = '{16'h0000, 16'h2000, 16'h0000, 16'h0000,
        16'h0028, 16'h0000, 16'h0000, 16'h0000};

    pmbus_link_if link_i ();
    pmbus_fault_status_bank pmbus_fault_status_bank_i (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .link(link_i), .busy_fault_in(lvl[0]), .channel_off_in(lvl[1]),
        .power_good_in(lvl[2]), .unlisted_fault_in(lvl[3]), .vout_cond_in(cond[0]),
        .iout_cond_in(cond[1]), .input_cond_in(cond[2]), .temp_cond_in(cond[3]),
        .cml_cond_in(cond[4]), .vendor_cond_in(cond[5]));
    pmbus_status_host pmbus_status_host_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .link(link_i), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .alert_out(alert));
    pmbus_fault_status_bank_props props_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .req(link_i.req), .wr(link_i.wr), .code(link_i.code), .ack(link_i.ack),
        .rdata(link_i.rdata));

    // Free-running clock, 25 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    // Prints the verdict and stops the run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        if (n >= 50) begin
            errors++;
            final_report();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Issues a link command and polls until the controller is idle again
    task automatic link_op(input logic w, input logic [7:0] c, input logic [15:0] d,
                           output logic [15:0] r);
        logic [31:0] q;
        logic        e;
        int          n;
        apb(1'b1, OFS_COMMAND, {d, 7'h00, w, c}, q, e);
        n = 0;
        q = 32'h0000_0001;
        while (q[RES_BUSY_BIT] !== 1'b0 && n < 20) begin
            apb(1'b0, OFS_RESULT, 32'h0000_0000, q, e);
            n++;
        end
        if (n >= 20) begin
            errors++;
            final_report();
        end
        r = q[31:16];
    endtask

    // Reads one status code and compares it
    task automatic chk_rd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] r;
        link_op(1'b0, c, 16'h0000, r);
        `CHK(r, e)
    endtask

    // Main sequence
    initial begin
        logic [31:0] q;
        logic [15:0] r;
        logic        e;
        errors = 0;
        tests_run = 0;
        reset_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        lvl = 4'b0100;
        foreach (cond[i]) cond[i] = 8'h00;
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        foreach (codes[i]) chk_rd(codes[i], 16'h0000);
        // Every condition at once; sync stage needs a few edges
        foreach (cond[i]) cond[i] <= 8'hFF;
        lvl <= 4'b1011;
        repeat (4) @(posedge clk_sys_in);
        foreach (cond[i]) cond[i] <= 8'h00;
        lvl <= 4'b0100;
        repeat (4) @(posedge clk_sys_in);
        foreach (codes[i]) chk_rd(codes[i], full[i]);
        `CHK(alert, 1'b1)
        // Write ones everywhere: input bits 5 and 3 must survive
        foreach (codes[i]) link_op(1'b1, codes[i], 16'h00FF, r);
        foreach (codes[i]) chk_rd(codes[i], left[i]);
        `CHK(alert, 1'b0)
        link_op(1'b1, CODE_CLEAR_ALL, 16'h0000, r);
        chk_rd(CODE_SUM_WORD, 16'h0000);
        // Live bits follow their pins and are not sticky
        lvl <= 4'b0010;
        repeat (4) @(posedge clk_sys_in);
        chk_rd(CODE_SUM_WORD, 16'h0840);
        lvl <= 4'b0100;
        // A fault still present stays set through the global clear
        cond[3] <= 8'h80;
        repeat (4) @(posedge clk_sys_in);
        link_op(1'b1, CODE_CLEAR_ALL, 16'h0000, r);
        chk_rd(CODE_TEMP, 16'h0080);
        `CHK(alert, 1'b1)
        link_op(1'b1, CODE_ALERT_MASK, 16'h0010, r);
        repeat (3) @(posedge clk_sys_in);
        `CHK(alert, 1'b0)
        chk_rd(CODE_SUM_BYTE, 16'h0004);
        cond[3] <= 8'h00;
        link_op(1'b1, CODE_ALERT_MASK, 16'h0000, r);
        link_op(1'b1, CODE_CLEAR_ALL, 16'h0000, r);
        // Unknown code still answered, with zero data
        link_op(1'b0, 8'h55, 16'h0000, r);
        `CHK(r, 16'h0000)
        chk_rd(CODE_CML, 16'h0080);
        chk_rd(CODE_SUM_BYTE, 16'h0002);
        apb(1'b0, 12'h008, 32'h0000_0000, q, e);
        `CHK(e, 1'b1)
        `CHK(q, 32'h0000_0000)
        final_report();
    end
endmodule
